// ### core/crmr_core.sv
// Clock ratio detection, sampling mode selection, reset sequencing and audio capture
//
// Behaviour
// R1 - System clock is an integer multiple: 128,192,256,384,512,768,1152 of frame rate.
// R2 - Auto mode: single for 512-1152, dual for 256/384, quad for 128/192.
// R3 - Manual mode overrides auto only for permitted mode and ratio combinations.
// R4 - Auto oversampling: x8/x128, x8/x64, x4/x32 by ratio group.
// R5 - Manual: single x8/x128 or x4/x64, dual x8/x64 or x4/x64, quad x4/x32.
// R6 - Ratios 128 and 192 always use the quad-rate filter characteristic.
// R7 - Far side keeps rates and ratios within the permitted table.
// R8 - Internal reset releases 3846 system clocks after power-on with reset pin high.
// R9 - Outputs sit at common mode during init, then reproduce data when synchronized.
// R10 - Without synchronization reset stays asserted and powered down, then re-sequences.
// R11 - Reset pin falling forces ground output, clears data and powers down.
// R12 - Reset pin rising repeats the power-on sequence.
// R13 - Word lengths 16-32 in I2S/left-justified, 24 bits in other formats.
// R14 - Samples are MSB first, two's complement.
// R15 - Serial input n feeds channels 2n-1 and 2n.
// R16 - Ratio is system clocks per frame; unsupported or unstable count means lost sync.
// R17 - Release counter starts at reset release and restarts when sync is lost.
`include "crmr_defines.svh"
module crmr_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  input wire logic bit_clk_i,
  input wire logic frame_select_clock_i,
  input wire logic serial_audio_in_1_i,
  input wire logic serial_audio_in_2_i,
  input wire logic serial_audio_in_3_i,
  input wire logic serial_audio_in_4_i,
  input crmr_pkg::crmr_sel_t mode_sel_i,
  input crmr_pkg::crmr_fmt_t fmt_i,
  input crmr_pkg::crmr_wlen_t word_len_i,
  output crmr_pkg::crmr_ratio_t ratio_o,
  output crmr_pkg::crmr_rate_t samp_rate_o,
  output crmr_pkg::crmr_fosr_t filt_osr_o,
  output crmr_pkg::crmr_mosr_t mod_osr_o,
  output logic quad_filter_o,
  output logic sync_ok_o,
  output logic internal_reset_o,
  output logic power_down_o,
  output crmr_pkg::crmr_out_t out_level_o,
  output logic [8*`CRMR_WORD_W-1:0] chan_data_o,
  output logic chan_valid_o
);
  localparam int LN = `CRMR_LANES;
  localparam int WW = `CRMR_WORD_W;
  localparam int SW = `CRMR_SHIFT_W;

  // System clock domain: pin synchronisers
  logic ext_s1_ff, ext_s2_ff;
  logic fr_s1_ff, fr_s2_ff, fr_s3_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      fr_s1_ff <= 1'b0;
      fr_s2_ff <= 1'b0;
      fr_s3_ff <= 1'b0;
    end
    else
    begin
      ext_s1_ff <= ext_reset_n_i;
      ext_s2_ff <= ext_s1_ff;
      fr_s1_ff <= frame_select_clock_i;
      fr_s2_ff <= fr_s1_ff;
      fr_s3_ff <= fr_s2_ff;
    end
  end
  logic fr_rise;
  assign fr_rise = fr_s2_ff && !fr_s3_ff;

  // Synchroniser jitter makes the count wander by one, hence the tolerance
  function automatic crmr_pkg::crmr_ratio_t ratio_of(input logic [`CRMR_CNT_W-1:0] c);
    logic [`CRMR_CNT_W-1:0] tab [7];
    crmr_pkg::crmr_ratio_t r;
    tab = '{`CRMR_R128, `CRMR_R192, `CRMR_R256, `CRMR_R384, `CRMR_R512, `CRMR_R768,
      `CRMR_R1152};
    r = crmr_pkg::RAT_NONE;
    for (int k = 0; k < 7; k++)
    begin
      if (c + `CRMR_RATIO_TOL >= tab[k] && c <= tab[k] + `CRMR_RATIO_TOL)
      begin
        r = crmr_pkg::crmr_ratio_t'(3'(k));
      end
    end
    return r;
  endfunction

  logic [`CRMR_CNT_W-1:0] per_cnt_ff;
  crmr_pkg::crmr_ratio_t ratio_ff, prev_ratio_ff;
  logic sync_ok_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      per_cnt_ff <= '0;
      ratio_ff <= crmr_pkg::RAT_NONE;
      prev_ratio_ff <= crmr_pkg::RAT_NONE;
      sync_ok_ff <= 1'b0;
    end
    else if (fr_rise)
    begin
      per_cnt_ff <= `CRMR_CNT_W'(1);
      prev_ratio_ff <= ratio_of(per_cnt_ff); // R16
      ratio_ff <= ratio_of(per_cnt_ff);
      sync_ok_ff <= ratio_of(per_cnt_ff) != crmr_pkg::RAT_NONE &&
        ratio_of(per_cnt_ff) == prev_ratio_ff; // R1 R16
    end
    else if (per_cnt_ff >= `CRMR_PERIOD_MAX)
    begin
      ratio_ff <= crmr_pkg::RAT_NONE; // R16
      sync_ok_ff <= 1'b0;
    end
    else
    begin
      per_cnt_ff <= per_cnt_ff + `CRMR_CNT_W'(1);
    end
  end

  // Sampling mode and oversampling selection
  logic r_lo, r_mid, r_hi;
  crmr_pkg::crmr_sel_t eff_sel;
  crmr_pkg::crmr_rate_t nxt_rate;
  crmr_pkg::crmr_fosr_t nxt_fosr;
  crmr_pkg::crmr_mosr_t nxt_mosr;
  always_comb
  begin
    r_lo = ratio_ff == crmr_pkg::RAT_128 || ratio_ff == crmr_pkg::RAT_192;
    r_mid = ratio_ff == crmr_pkg::RAT_256 || ratio_ff == crmr_pkg::RAT_384;
    r_hi = ratio_ff == crmr_pkg::RAT_512 || ratio_ff == crmr_pkg::RAT_768 ||
      ratio_ff == crmr_pkg::RAT_1152;
    eff_sel = crmr_pkg::SEL_AUTO;
    if (mode_sel_i == crmr_pkg::SEL_SINGLE || (mode_sel_i == crmr_pkg::SEL_DUAL && !r_hi) ||
        (mode_sel_i == crmr_pkg::SEL_QUAD && r_lo))
    begin
      eff_sel = mode_sel_i; // R3
    end
    nxt_fosr = r_lo ? crmr_pkg::FOSR_X4 : crmr_pkg::FOSR_X8;
    case (eff_sel)
      crmr_pkg::SEL_SINGLE:
      begin
        nxt_rate = crmr_pkg::RATE_SINGLE; // R5
        nxt_mosr = r_lo ? crmr_pkg::MOSR_X64 : crmr_pkg::MOSR_X128;
      end
      crmr_pkg::SEL_DUAL:
      begin
        nxt_rate = crmr_pkg::RATE_DUAL; // R5
        nxt_mosr = crmr_pkg::MOSR_X64;
      end
      crmr_pkg::SEL_QUAD:
      begin
        nxt_rate = crmr_pkg::RATE_QUAD; // R5
        nxt_mosr = crmr_pkg::MOSR_X32;
      end
      default:
      begin
        nxt_rate = r_hi ? crmr_pkg::RATE_SINGLE :
          (r_mid ? crmr_pkg::RATE_DUAL : crmr_pkg::RATE_QUAD); // R2
        nxt_mosr = r_hi ? crmr_pkg::MOSR_X128 :
          (r_mid ? crmr_pkg::MOSR_X64 : crmr_pkg::MOSR_X32); // R4
      end
    endcase
  end

  crmr_pkg::crmr_rate_t rate_ff;
  crmr_pkg::crmr_fosr_t fosr_ff;
  crmr_pkg::crmr_mosr_t mosr_ff;
  logic quad_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_ff <= crmr_pkg::RATE_SINGLE;
      fosr_ff <= crmr_pkg::FOSR_X8;
      mosr_ff <= crmr_pkg::MOSR_X128;
      quad_ff <= 1'b0;
    end
    else
    begin
      rate_ff <= nxt_rate;
      fosr_ff <= nxt_fosr;
      mosr_ff <= nxt_mosr;
      quad_ff <= r_lo; // R6
    end
  end

  // Reset sequencer
  crmr_pkg::crmr_rst_t rst_st_ff;
  crmr_pkg::crmr_out_t out_ff;
  logic [11:0] rel_cnt_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_st_ff <= crmr_pkg::RST_COUNT;
      out_ff <= crmr_pkg::OUT_COMMON;
      rel_cnt_ff <= '0;
    end
    else if (!ext_s2_ff)
    begin
      rst_st_ff <= crmr_pkg::RST_HELD; // R11
      out_ff <= crmr_pkg::OUT_GROUND;
      rel_cnt_ff <= '0;
    end
    else
    begin
      case (rst_st_ff)
        crmr_pkg::RST_HELD:
        begin
          rst_st_ff <= crmr_pkg::RST_COUNT; // R12
          out_ff <= crmr_pkg::OUT_COMMON;
          rel_cnt_ff <= '0;
        end
        crmr_pkg::RST_COUNT:
        begin
          out_ff <= crmr_pkg::OUT_COMMON; // R9
          if (!sync_ok_ff)
          begin
            rel_cnt_ff <= '0; // R10 R17
          end
          else if (rel_cnt_ff == `CRMR_RELEASE_CYC - 12'd1)
          begin
            rst_st_ff <= crmr_pkg::RST_RUN; // R8
            out_ff <= crmr_pkg::OUT_ACTIVE;
          end
          else
          begin
            rel_cnt_ff <= rel_cnt_ff + 12'd1;
          end
        end
        crmr_pkg::RST_RUN:
        begin
          if (!sync_ok_ff)
          begin
            rst_st_ff <= crmr_pkg::RST_COUNT; // R10
            out_ff <= crmr_pkg::OUT_COMMON;
            rel_cnt_ff <= '0;
          end
        end
        default:
        begin
          rst_st_ff <= crmr_pkg::RST_HELD;
          out_ff <= crmr_pkg::OUT_GROUND;
        end
      endcase
    end
  end

  // Registered first so the crossing never sees a gate glitch
  logic link_hold_ff;
  always_ff @(posedge clk_i)
  begin
    link_hold_ff <= rst_i || rst_st_ff == crmr_pkg::RST_HELD;
  end

  // Link domain: reset and configuration cross in on two flops each
  logic lrst_s1_ff, lrst_s2_ff;
  crmr_pkg::crmr_fmt_t fmt_s1_ff, fmt_s2_ff;
  crmr_pkg::crmr_wlen_t wl_s1_ff, wl_s2_ff;
  always_ff @(posedge bit_clk_i)
  begin
    lrst_s1_ff <= link_hold_ff;
    lrst_s2_ff <= lrst_s1_ff;
    fmt_s1_ff <= fmt_i;
    fmt_s2_ff <= fmt_s1_ff;
    wl_s1_ff <= word_len_i;
    wl_s2_ff <= wl_s1_ff;
  end

  logic fr_q_ff;
  logic [6:0] bcnt_ff;
  logic [LN-1:0] din;
  logic fedge, dsp_fmt, restart;
  assign din = {serial_audio_in_4_i, serial_audio_in_3_i, serial_audio_in_2_i,
    serial_audio_in_1_i};
  assign fedge = frame_select_clock_i != fr_q_ff;
  assign dsp_fmt = fmt_s2_ff == crmr_pkg::FMT_DSP || fmt_s2_ff == crmr_pkg::FMT_TDM;
  assign restart = dsp_fmt ? (frame_select_clock_i && !fr_q_ff) : fedge;
  always_ff @(posedge bit_clk_i)
  begin
    if (lrst_s2_ff)
    begin
      fr_q_ff <= 1'b0;
      bcnt_ff <= '0;
    end
    else
    begin
      fr_q_ff <= frame_select_clock_i;
      if (restart)
      begin
        bcnt_ff <= 7'd1;
      end
      else if (bcnt_ff != `CRMR_BCNT_MAX)
      begin
        bcnt_ff <= bcnt_ff + 7'd1;
      end
    end
  end

  // Only 24-bit words outside I2S and left-justified
  crmr_pkg::crmr_wlen_t eff_wl;
  logic [6:0] wl_bits;
  logic hit_mid, hit_rj, hit_dsp, hit_left, hit_any;
  always_comb
  begin
    eff_wl = (fmt_s2_ff == crmr_pkg::FMT_I2S || fmt_s2_ff == crmr_pkg::FMT_LJ) ?
      wl_s2_ff : crmr_pkg::WL_24; // R13
    case (eff_wl)
      crmr_pkg::WL_16: wl_bits = 7'd16;
      crmr_pkg::WL_20: wl_bits = 7'd20;
      crmr_pkg::WL_32: wl_bits = 7'd32;
      default: wl_bits = 7'd24;
    endcase
    hit_mid = (fmt_s2_ff == crmr_pkg::FMT_LJ && bcnt_ff == wl_bits) ||
      (fmt_s2_ff == crmr_pkg::FMT_I2S && bcnt_ff == wl_bits + 7'd1);
    hit_rj = fmt_s2_ff == crmr_pkg::FMT_RJ && fedge;
    hit_dsp = dsp_fmt && (bcnt_ff == `CRMR_DSP_LEFT || bcnt_ff == `CRMR_DSP_RIGHT);
    hit_any = (hit_mid || hit_rj || hit_dsp) && !lrst_s2_ff;
    if (hit_dsp)
    begin
      hit_left = bcnt_ff == `CRMR_DSP_LEFT;
    end
    else
    begin
      hit_left = (fmt_s2_ff == crmr_pkg::FMT_I2S) ? !fr_q_ff : fr_q_ff;
    end
  end

  // MSB-first words left-aligned into 24 bits keep two's complement sign
  function automatic logic [WW-1:0] align(input logic [SW-1:0] s,
    input crmr_pkg::crmr_wlen_t wl);
    case (wl)
      crmr_pkg::WL_16: return {s[15:0], 8'h00};
      crmr_pkg::WL_20: return {s[19:0], 4'h0};
      crmr_pkg::WL_32: return s[31:8];
      default: return s[23:0];
    endcase
  endfunction

  logic [SW-1:0] sh_ff [LN];
  logic [WW-1:0] lat_l_ff [LN];
  logic [WW-1:0] lat_r_ff [LN];
  for (genvar i = 0; i < LN; i++)
  begin : g_lane
    always_ff @(posedge bit_clk_i)
    begin
      sh_ff[i] <= {sh_ff[i][SW-2:0], din[i]}; // R14
    end
    always_ff @(posedge bit_clk_i)
    begin
      if (lrst_s2_ff)
      begin
        lat_l_ff[i] <= '0;
        lat_r_ff[i] <= '0;
      end
      else if (hit_any && hit_left)
      begin
        lat_l_ff[i] <= align(sh_ff[i], eff_wl); // R14
      end
      else if (hit_any)
      begin
        lat_r_ff[i] <= align(sh_ff[i], eff_wl);
      end
    end
  end

  logic pair_tgl_ff;
  always_ff @(posedge bit_clk_i)
  begin
    if (lrst_s2_ff)
    begin
      pair_tgl_ff <= 1'b0;
    end
    else if (hit_any && !hit_left)
    begin
      pair_tgl_ff <= !pair_tgl_ff;
    end
  end

  // Words held a full frame, so a synchronised toggle makes them safe to copy
  logic tg_s1_ff, tg_s2_ff, tg_s3_ff;
  logic [8*WW-1:0] chan_ff;
  logic valid_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tg_s1_ff <= 1'b0;
      tg_s2_ff <= 1'b0;
      tg_s3_ff <= 1'b0;
    end
    else
    begin
      tg_s1_ff <= pair_tgl_ff;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
    end
  end
  always_ff @(posedge clk_i)
  begin
    // Pin low clears in the same cycle as the state, not one later
    if (rst_i || !ext_s2_ff || rst_st_ff != crmr_pkg::RST_RUN)
    begin
      chan_ff <= '0; // R11
      valid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= tg_s2_ff != tg_s3_ff;
      if (tg_s2_ff != tg_s3_ff)
      begin
        for (int n = 0; n < LN; n++)
        begin
          chan_ff[2*n*WW +: WW] <= lat_l_ff[n]; // R15
          chan_ff[(2*n+1)*WW +: WW] <= lat_r_ff[n];
        end
      end
    end
  end

  assign ratio_o = ratio_ff;
  assign samp_rate_o = rate_ff;
  assign filt_osr_o = fosr_ff;
  assign mod_osr_o = mosr_ff;
  assign quad_filter_o = quad_ff;
  assign sync_ok_o = sync_ok_ff;
  assign internal_reset_o = rst_st_ff != crmr_pkg::RST_RUN;
  assign power_down_o = rst_st_ff == crmr_pkg::RST_HELD || !sync_ok_ff; // R10
  assign out_level_o = out_ff;
  assign chan_data_o = chan_ff;
  assign chan_valid_o = valid_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pin_low_high;
    !ext_s2_ff ##1 ext_s2_ff;
  endsequence
  sequence s_count_done;
    rst_st_ff == crmr_pkg::RST_COUNT && sync_ok_ff && ext_s2_ff &&
      rel_cnt_ff == `CRMR_RELEASE_CYC - 12'd1;
  endsequence

  a_release_count: assert property ($rose(rst_st_ff == crmr_pkg::RST_RUN) |-> // R8
    $past(rel_cnt_ff) == `CRMR_RELEASE_CYC - 12'd1 && out_ff == crmr_pkg::OUT_ACTIVE)
    else $error("release not after full count");
  a_release_step: assert property (s_count_done |=> !internal_reset_o) // R8
    else $error("count done but reset held");
  a_pin_ground: assert property (!ext_s2_ff |=> out_level_o == crmr_pkg::OUT_GROUND && // R11
    power_down_o && chan_data_o == '0) else $error("reset pin low not grounded");
  a_pin_resequence: assert property (s_pin_low_high |=> // R12
    out_level_o == crmr_pkg::OUT_COMMON && rel_cnt_ff == 12'd0)
    else $error("reset pin release did not restart");
  a_sync_lost: assert property (!sync_ok_ff && ext_s2_ff |=> internal_reset_o && // R10
    rel_cnt_ff == 12'd0) else $error("reset released without sync");
  a_auto_single: assert property (mode_sel_i == crmr_pkg::SEL_AUTO && r_hi |=> // R2
    samp_rate_o == crmr_pkg::RATE_SINGLE && mod_osr_o == crmr_pkg::MOSR_X128)
    else $error("auto high ratio not single");
  a_auto_osr: assert property (mode_sel_i == crmr_pkg::SEL_AUTO && r_mid |=> // R4
    filt_osr_o == crmr_pkg::FOSR_X8 && mod_osr_o == crmr_pkg::MOSR_X64)
    else $error("auto mid ratio oversampling wrong");
  a_manual_bad: assert property (mode_sel_i == crmr_pkg::SEL_QUAD && !r_lo && r_mid |=> // R3
    samp_rate_o == crmr_pkg::RATE_DUAL) else $error("illegal quad not refused");
  a_single_low: assert property (mode_sel_i == crmr_pkg::SEL_SINGLE && r_lo |=> // R5
    filt_osr_o == crmr_pkg::FOSR_X4 && mod_osr_o == crmr_pkg::MOSR_X64)
    else $error("single low ratio oversampling wrong");
  a_quad_filter: assert property (r_lo |=> quad_filter_o) // R6
    else $error("quad filter not applied");
endmodule // crmr_core

// ### pkg/crmr_defines.svh
// Timing counts, ratio table and widths of the clock-ratio and reset block
`ifndef CRMR_DEFINES_SVH
`define CRMR_DEFINES_SVH
`define CRMR_RELEASE_CYC 12'd3846
`define CRMR_CNT_W 11
`define CRMR_PERIOD_MAX 11'd1200
`define CRMR_RATIO_TOL 11'd1
`define CRMR_R128 11'd128
`define CRMR_R192 11'd192
`define CRMR_R256 11'd256
`define CRMR_R384 11'd384
`define CRMR_R512 11'd512
`define CRMR_R768 11'd768
`define CRMR_R1152 11'd1152
`define CRMR_WORD_W 24
`define CRMR_SHIFT_W 32
`define CRMR_LANES 4
`define CRMR_BCNT_MAX 7'd127
`define CRMR_DSP_LEFT 7'd25
`define CRMR_DSP_RIGHT 7'd49
`endif

// ### pkg/crmr_pkg.sv
// Types of the clock-ratio and reset block
package crmr_pkg;
  typedef enum logic [1:0] {SEL_AUTO, SEL_SINGLE, SEL_DUAL, SEL_QUAD} crmr_sel_t;
  typedef enum logic [1:0] {RATE_SINGLE, RATE_DUAL, RATE_QUAD} crmr_rate_t;
  typedef enum logic [2:0] {RAT_128, RAT_192, RAT_256, RAT_384, RAT_512, RAT_768, RAT_1152,
    RAT_NONE} crmr_ratio_t;
  typedef enum logic {FOSR_X4, FOSR_X8} crmr_fosr_t;
  typedef enum logic [1:0] {MOSR_X32, MOSR_X64, MOSR_X128} crmr_mosr_t;
  typedef enum logic [2:0] {FMT_I2S, FMT_LJ, FMT_RJ, FMT_DSP, FMT_TDM} crmr_fmt_t;
  typedef enum logic [1:0] {WL_16, WL_20, WL_24, WL_32} crmr_wlen_t;
  typedef enum logic [1:0] {OUT_GROUND, OUT_COMMON, OUT_ACTIVE} crmr_out_t;
  typedef enum logic [1:0] {RST_HELD, RST_COUNT, RST_RUN} crmr_rst_t;
endpackage

// ### testbench/crmr_audio_src.sv
// Behavioural audio processor: frame clock, bit clock and serial data
module crmr_audio_src (
  output logic bit_clk_o,
  output logic frame_o,
  output logic [3:0] din_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Frame period is ratio * 5 ns; 0 stops the frames
  int ratio = 1152;
  logic [15:0] left_w [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] right_w [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  initial
  begin
    bit_clk_o = 1'b0;
    frame_o = 1'b0;
    din_o = 4'h5;
    #1.3;
    forever
    begin
      if (ratio == 0)
      begin
        din_o = ~din_o;
        #125;
      end
      else if (ratio == 1152)
      begin
        // 32 bits of 125 ns only fit the longest frame; clock then stands still
        for (int b = 0; b < 32; b++)
        begin
          frame_o = (b < 16);
          for (int n = 0; n < 4; n++)
            din_o[n] = (b < 16) ? left_w[n][15-b] : right_w[n][31-b];
          #62.5;
          bit_clk_o = 1'b1;
          #62.5;
          bit_clk_o = 1'b0;
        end
        din_o = ~din_o;
        #1760;
      end
      else
      begin
        frame_o = 1'b1;
        din_o = ~din_o;
        #(ratio * 2.5);
        frame_o = 1'b0;
        din_o = ~din_o;
        #(ratio * 2.5);
      end
    end
  end
endmodule // crmr_audio_src

// ### testbench/crmr_core_tb.sv
// Self-checking bench of the clock ratio and reset block
module crmr_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, ext_reset_n_i;
  wire bit_clk, frame;
  wire [3:0] din;
  crmr_pkg::crmr_sel_t mode_sel_i;
  crmr_pkg::crmr_fmt_t fmt_i;
  crmr_pkg::crmr_wlen_t word_len_i;
  crmr_pkg::crmr_ratio_t ratio_o;
  crmr_pkg::crmr_rate_t samp_rate_o;
  crmr_pkg::crmr_fosr_t filt_osr_o;
  crmr_pkg::crmr_mosr_t mod_osr_o;
  crmr_pkg::crmr_out_t out_level_o;
  logic quad_filter_o, sync_ok_o, internal_reset_o, power_down_o, chan_valid_o;
  logic [191:0] chan_data_o;
  int fail_count = 0;
  int n_checks = 0;

  crmr_audio_src src (.bit_clk_o(bit_clk), .frame_o(frame), .din_o(din));
  crmr_core DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i),
    .bit_clk_i(bit_clk), .frame_select_clock_i(frame),
    .serial_audio_in_1_i(din[0]), .serial_audio_in_2_i(din[1]),
    .serial_audio_in_3_i(din[2]), .serial_audio_in_4_i(din[3]),
    .mode_sel_i(mode_sel_i), .fmt_i(fmt_i), .word_len_i(word_len_i),
    .ratio_o(ratio_o), .samp_rate_o(samp_rate_o), .filt_osr_o(filt_osr_o),
    .mod_osr_o(mod_osr_o), .quad_filter_o(quad_filter_o), .sync_ok_o(sync_ok_o),
    .internal_reset_o(internal_reset_o), .power_down_o(power_down_o),
    .out_level_o(out_level_o), .chan_data_o(chan_data_o), .chan_valid_o(chan_valid_o));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [191:0] got, input logic [191:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Settles several frames so two equal periods have been measured
  task automatic wf(input int n);
    repeat (n) @(posedge frame);
    repeat (8) @(negedge clk_i);
  endtask

  task automatic t_release(input string what);
    int n;
    n = 0;
    while (sync_ok_o !== 1'b1 && n < 40000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(sync_ok_o, 1'b1, "sync before release");
    n = 0;
    while (internal_reset_o === 1'b1 && n < 5000)
    begin
      @(negedge clk_i);
      n++;
      if (n == 2000)
        chk(out_level_o, crmr_pkg::OUT_COMMON, "level while counting");
    end
    // One cycle of slack for the registered sync flag
    chk(n >= 3846 && n <= 3847, 1'b1, "release count");
    chk(out_level_o, crmr_pkg::OUT_ACTIVE, "level after release");
    $display("t_release %s done", what);
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    @(negedge clk_i);
    while (chan_valid_o !== 1'b1 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(chan_valid_o, 1'b1, "valid pulse");
  endtask

  task automatic t_capture();
    logic [191:0] exp;
    for (int n = 0; n < 4; n++)
    begin
      src.left_w[n] = 16'h8a01 + 16'(n);
      src.right_w[n] = 16'h357e - 16'(n);
      exp[48*n +: 24] = {src.left_w[n], 8'h00};
      exp[48*n+24 +: 24] = {src.right_w[n], 8'h00};
    end
    wait_valid();
    wait_valid();
    chk(chan_data_o, exp, "channel data");
    @(negedge clk_i);
    chk(chan_valid_o, 1'b0, "valid one cycle");
    $display("t_capture done");
  endtask

  task automatic t_ext_reset();
    int n;
    n = 0;
    ext_reset_n_i = 1'b0;
    while (out_level_o !== crmr_pkg::OUT_GROUND && n < 10)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n, 3, "ground delay");
    chk(internal_reset_o, 1'b1, "reset on pin");
    chk(power_down_o, 1'b1, "power down on pin");
    repeat (50) @(negedge clk_i);
    chk(chan_data_o, 192'h0, "data cleared");
    ext_reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(out_level_o, crmr_pkg::OUT_COMMON, "level after pin");
    t_release("pin");
  endtask

  task automatic t_sync_loss();
    int n;
    n = 0;
    src.ratio = 0;
    while (sync_ok_o === 1'b1 && n < 2600)
    begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    chk(sync_ok_o, 1'b0, "sync lost");
    chk(internal_reset_o, 1'b1, "reset on loss");
    chk(power_down_o, 1'b1, "power down on loss");
    chk(out_level_o, crmr_pkg::OUT_COMMON, "level on loss");
    src.ratio = 1152;
    t_release("resync");
  endtask

  task automatic t_auto();
    int r [7] = '{128, 192, 256, 384, 512, 768, 1152};
    mode_sel_i = crmr_pkg::SEL_AUTO;
    for (int i = 0; i < 7; i++)
    begin
      src.ratio = r[i];
      wf(4);
      chk(ratio_o, i, "ratio code");
      chk(sync_ok_o, 1'b1, "sync");
      chk(samp_rate_o, (i > 3) ? crmr_pkg::RATE_SINGLE : (i > 1) ? crmr_pkg::RATE_DUAL
        : crmr_pkg::RATE_QUAD, "auto rate");
      chk(filt_osr_o, (i > 1) ? crmr_pkg::FOSR_X8 : crmr_pkg::FOSR_X4, "auto filter");
      chk(mod_osr_o, (i > 3) ? crmr_pkg::MOSR_X128 : (i > 1) ? crmr_pkg::MOSR_X64
        : crmr_pkg::MOSR_X32, "auto modulator");
      chk(quad_filter_o, i < 2, "auto quad filter");
    end
    $display("t_auto done");
  endtask

  task automatic t_man(input int r, input crmr_pkg::crmr_sel_t s, input crmr_pkg::crmr_rate_t er,
    input crmr_pkg::crmr_fosr_t ef, input crmr_pkg::crmr_mosr_t em);
    mode_sel_i = s;
    src.ratio = r;
    wf(4);
    chk(samp_rate_o, er, "manual rate");
    chk(filt_osr_o, ef, "manual filter");
    chk(mod_osr_o, em, "manual modulator");
    chk(quad_filter_o, r < 256, "manual quad filter");
    $display("t_man %0d done", r);
  endtask

  task automatic t_bad_ratio();
    src.ratio = 300;
    wf(4);
    chk(ratio_o, crmr_pkg::RAT_NONE, "odd ratio");
    chk(sync_ok_o, 1'b0, "odd ratio sync");
    chk(internal_reset_o, 1'b1, "odd ratio reset");
    $display("t_bad_ratio done");
  endtask

  initial
  begin
    #450000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  initial
  begin
    rst_i = 1'b1;
    ext_reset_n_i = 1'b0;
    mode_sel_i = crmr_pkg::SEL_AUTO;
    fmt_i = crmr_pkg::FMT_LJ;
    word_len_i = crmr_pkg::WL_16;
    repeat (20) @(negedge clk_i);
    chk(internal_reset_o, 1'b1, "reset value");
    chk(out_level_o, crmr_pkg::OUT_COMMON, "reset level");
    chk(ratio_o, crmr_pkg::RAT_NONE, "reset ratio");
    chk(sync_ok_o, 1'b0, "reset sync");
    rst_i = 1'b0;
    // Pin held so the link side sees bit clock edges in reset
    repeat (200) @(negedge clk_i);
    ext_reset_n_i = 1'b1;
    t_release("power-on");
    t_capture();
    t_ext_reset();
    t_sync_loss();
    t_auto();
    t_man(256, crmr_pkg::SEL_SINGLE, crmr_pkg::RATE_SINGLE, crmr_pkg::FOSR_X8,
      crmr_pkg::MOSR_X128);
    t_man(256, crmr_pkg::SEL_DUAL, crmr_pkg::RATE_DUAL, crmr_pkg::FOSR_X8,
      crmr_pkg::MOSR_X64);
    t_man(384, crmr_pkg::SEL_QUAD, crmr_pkg::RATE_DUAL, crmr_pkg::FOSR_X8,
      crmr_pkg::MOSR_X64);
    t_man(128, crmr_pkg::SEL_SINGLE, crmr_pkg::RATE_SINGLE, crmr_pkg::FOSR_X4,
      crmr_pkg::MOSR_X64);
    t_man(192, crmr_pkg::SEL_DUAL, crmr_pkg::RATE_DUAL, crmr_pkg::FOSR_X4,
      crmr_pkg::MOSR_X64);
    t_man(128, crmr_pkg::SEL_QUAD, crmr_pkg::RATE_QUAD, crmr_pkg::FOSR_X4,
      crmr_pkg::MOSR_X32);
    t_man(512, crmr_pkg::SEL_DUAL, crmr_pkg::RATE_SINGLE, crmr_pkg::FOSR_X8,
      crmr_pkg::MOSR_X128);
    t_bad_ratio();
    results();
  end
endmodule // crmr_core_tb
